// ### design/adc_config_irq.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////
// Converter configuration, result placement and flag logic
////////////////////////////////////////////////////////////////////
module adc_config_irq (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Converter events
  input  wire logic        cal_done,
  input  wire logic [15:0] cal_result,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  // Analog controls
  output logic [2:0]       input_channel_select,
  output logic [1:0]       reference_level_select,
  output logic [1:0]       oversample_ratio_select,
  output logic [1:0]       attenuator_select,
  output logic             repeat_convert,
  output logic             filter_bypass,
  output logic             window_compare_enable,
  // Stored words
  output logic [31:0]      data_word,
  output logic [31:0]      offset_word,
  // Microphone clock pin
  output logic             microphone_clock_pin,
  output logic             microphone_clock_pin_oe
);

  ////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////
  // Register bank and its next value
  adc_cfg_pkg::regs_t st_reg;  // All registers
  adc_cfg_pkg::regs_t st_next; // Their next value
  // Flag bookkeeping
  logic [31:0]        shown;   // Flags visible through mask
  logic [31:0]        clr;     // Flags cleared by a read
  logic [31:0]        setv;    // Flags set by events
  // Result path and decoded bits
  logic [31:0]        new_data; // Data word after this cycle
  logic               skip;    // Filter bypass in force
  logic               cmp_on;  // Comparator enabled
  logic               hit;     // Result lies in the window

  // Controls go down, the clock comes back
  mic_clk_if mic_bus (); // Link to clock generator

  ////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////
  // Address match, used by write, read and clear decode
  // Exact byte match: misaligned is unmapped
  function automatic logic at(input logic [7:0] a,
                              input logic [7:0] off);
    at = (a == off);
  endfunction

  // Masked write of one register
  // Read-only bits keep their old value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [31:0] m);
    wmerge = (old & ~m) | (nw & m);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Decoded fields
  ////////////////////////////////////////////////////////////////
  // Bypass and comparator enable come from held state
  // A write acts from the next cycle on
  assign skip   = st_reg.adc_configuration[adc_cfg_pkg::SKIP_BIT];
  assign cmp_on = st_reg.ctrl[adc_cfg_pkg::CMP_EN_BIT];

  // Masked view: a mask bit of one hides its flag
  // Reserved bit 1 is never shown
  assign shown = st_reg.raw & ~st_reg.mask
                 & adc_cfg_pkg::FLAG_BITS;

  ////////////////////////////////////////////////////////////////
  // Result placement
  ////////////////////////////////////////////////////////////////
  // Result lands in the half picked by the bypass bit.
  // The other half is left as it was; software ignores it.
  // Result bus ignored outside the event
  always_comb begin
    new_data = st_reg.data;
    if (conv_done) begin
      if (skip) begin
        // Bypassed: low half
        new_data[15:0]  = conv_result;
      end else begin
        // Filter in path: high half
        new_data[31:16] = conv_result;
      end
    end
  end

  // Window check on the freshly placed word, both ends inclusive
  // Unsigned, stale half included;
  // limits with lo above hi never hit
  assign hit = (new_data >= st_reg.thr_lo) &&
               (new_data <= st_reg.thr_hi);

  ////////////////////////////////////////////////////////////////
  // Flag sources and read clears
  ////////////////////////////////////////////////////////////////
  // Events raise flags; a read clears what it returned
  // The two status reads differ by address,
  // so at most one loads clr per cycle
  always_comb begin
    setv = '0;
    clr  = '0;
    // Calibration finished
    // A held pulse keeps the flag set
    if (cal_done) begin
      setv[adc_cfg_pkg::FLAG_CAL] = 1'b1;
    end
    // Conversion finished
    // Window outcome handled below
    if (conv_done) begin
      setv[adc_cfg_pkg::FLAG_EOC] = 1'b1;
    end
    // Masked status read clears only visible flags
    // Hidden flags survive until unmasked or cleared by a raw read
    if (rd && at(addr, adc_cfg_pkg::OFF_IRQ)) begin
      clr = shown;
    end
    // Raw status read clears every flag it shows
    // Addresses never overlap
    if (rd && at(addr, adc_cfg_pkg::OFF_RAW)) begin
      clr = st_reg.raw & adc_cfg_pkg::FLAG_BITS;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Next register state
  ////////////////////////////////////////////////////////////////
  // Software writes first, then hardware events on top, so a
  // converter update in the same cycle is never overwritten.
  // Read data is zero unless reloaded
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = '0;
    // Register writes
    if (wr) begin
      case (1'b1)
        at(addr, adc_cfg_pkg::OFF_CTRL): begin
          // Only comparator enable sticks
          st_next.ctrl = wmerge(st_reg.ctrl, wdata,
                                adc_cfg_pkg::CTRL_WMASK);
        end
        at(addr, adc_cfg_pkg::OFF_ADC_CONFIGURATION): begin
          // Reserved bits stay zero
          st_next.adc_configuration = wmerge(st_reg.adc_configuration, wdata,
                                adc_cfg_pkg::ADC_CONFIGURATION_WMASK);
        end
        at(addr, adc_cfg_pkg::OFF_MASK): begin
          // Reserved bit 1 kept as written
          st_next.mask = wmerge(st_reg.mask, wdata,
                                adc_cfg_pkg::MASK_WMASK);
        end
        at(addr, adc_cfg_pkg::OFF_OFFSET): begin
          // Whole word; calibration wins
          st_next.offs = wdata;
        end
        at(addr, adc_cfg_pkg::OFF_THR_HI): begin
          // Upper window limit
          st_next.thr_hi = wdata;
        end
        at(addr, adc_cfg_pkg::OFF_THR_LO): begin
          // Lower window limit
          st_next.thr_lo = wdata;
        end
        default: begin
          // Read-only or unmapped: write ignored
          // Flags clear only by reading
        end
      endcase
    end
    // Register reads, answered next cycle
    // Never together with a write
    if (rd) begin
      case (1'b1)
        at(addr, adc_cfg_pkg::OFF_CTRL): begin
          // Only bit 5 can read as one
          st_next.rdata = st_reg.ctrl;
        end
        at(addr, adc_cfg_pkg::OFF_ADC_CONFIGURATION): begin
          // Reserved bits read zero
          st_next.rdata = st_reg.adc_configuration;
        end
        at(addr, adc_cfg_pkg::OFF_IRQ): begin
          // Flags as held before the read
          st_next.rdata = shown;
        end
        at(addr, adc_cfg_pkg::OFF_MASK): begin
          // Mask as written
          st_next.rdata = st_reg.mask;
        end
        at(addr, adc_cfg_pkg::OFF_RAW): begin
          // Masked flags shown too
          st_next.rdata = st_reg.raw;
        end
        at(addr, adc_cfg_pkg::OFF_DATA): begin
          // Both halves, stale one too
          st_next.rdata = st_reg.data;
        end
        at(addr, adc_cfg_pkg::OFF_OFFSET): begin
          // Last written or calibrated
          st_next.rdata = st_reg.offs;
        end
        at(addr, adc_cfg_pkg::OFF_THR_HI): begin
          // Upper limit
          st_next.rdata = st_reg.thr_hi;
        end
        at(addr, adc_cfg_pkg::OFF_THR_LO): begin
          // Lower limit
          st_next.rdata = st_reg.thr_lo;
        end
        default: begin
          // Unmapped reads return zero
          // Misaligned ones included
          st_next.rdata = '0;
        end
      endcase
    end
    // Calibration result into the half the bypass bit selects
    // After the write, so the event wins
    if (cal_done) begin
      if (skip) begin
        st_next.offs[15:0]  = cal_result;
      end else begin
        st_next.offs[31:16] = cal_result;
      end
    end
    // Conversion result stored
    // Data is not writable
    st_next.data = new_data;
    // Flags: set wins over a clear in the same cycle
    // Bit 1 is never set
    for (int i = 0; i < adc_cfg_pkg::NFLAG; i++) begin
      st_next.raw[i] = (st_reg.raw[i] & ~clr[i]) | setv[i];
    end
    // Window flag follows each new result while enabled
    // Without the enable it holds
    if (conv_done && cmp_on) begin
      st_next.raw[adc_cfg_pkg::FLAG_WIN] = hit;
    end
    // Pin enable trails the clock-out bit
    st_next.mic_oe = st_reg.adc_configuration[adc_cfg_pkg::MICOUT_BIT];
  end

  ////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////
  // Whole state in one flop bank, frozen while ce is low
  // Keeps flags and read data coherent
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg.ctrl   <= adc_cfg_pkg::CTRL_RST;
      st_reg.adc_configuration   <= adc_cfg_pkg::ADC_CONFIGURATION_RST;
      st_reg.mask   <= adc_cfg_pkg::MASK_RST;
      st_reg.raw    <= adc_cfg_pkg::ZERO_RST;
      st_reg.data   <= adc_cfg_pkg::ZERO_RST;
      st_reg.offs   <= adc_cfg_pkg::ZERO_RST;
      st_reg.thr_hi <= adc_cfg_pkg::THR_HI_RST;
      st_reg.thr_lo <= adc_cfg_pkg::ZERO_RST;
      st_reg.rdata  <= adc_cfg_pkg::ZERO_RST;
      st_reg.mic_oe <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Microphone clock
  ////////////////////////////////////////////////////////////////
  // Rate and enable straight from the configuration word
  // Phase restarts whenever disabled
  assign mic_bus.rate_slow  = st_reg.adc_configuration[adc_cfg_pkg::RATE_BIT];
  assign mic_bus.out_enable = st_reg.adc_configuration[adc_cfg_pkg::MICOUT_BIT];

  // Generator instance
  // Shares ce, so the pin freezes too
  mic_clk_gen u_mic_clk (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .mic  (mic_bus.gen)
  );

  ////////////////////////////////////////////////////////////////
  // Outputs, all taken from flops
  ////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  // Zero otherwise, so it can be or-ed
  assign rdata = st_reg.rdata;

  // Channel routing code, reset to the shorted setting
  // Code 111 passed unchanged
  assign input_channel_select =
    st_reg.adc_configuration[adc_cfg_pkg::INPUT_CHANNEL_SELECT_LSB +: 3];

  // Reference level; reset code is 0.0 V, 0.6 V advised
  assign reference_level_select =
    st_reg.adc_configuration[adc_cfg_pkg::REF_LSB +: 2];

  // Ratio codes 0..3 mean 200, 100, 64, 32
  // Largest ratio suits DC inputs
  assign oversample_ratio_select =
    st_reg.adc_configuration[adc_cfg_pkg::OSR_LSB +: 2];

  // Attenuator code; code 3 is undefined, passed unchanged
  assign attenuator_select =
    st_reg.adc_configuration[adc_cfg_pkg::ATT_LSB +: 2];

  // Single versus continuous conversion
  // Software drops early results
  assign repeat_convert =
    st_reg.adc_configuration[adc_cfg_pkg::REPEAT_BIT];

  // Compensation filter bypass toward the converter
  // A change calls for recalibration
  assign filter_bypass = skip;

  // Comparator enable for the converter side
  assign window_compare_enable = cmp_on;

  // Stored result and calibration words
  // Software picks the half in use
  assign data_word   = st_reg.data;
  assign offset_word = st_reg.offs;

  // Clock pin and its enable
  // Pin low whenever no clock offered
  assign microphone_clock_pin    = mic_bus.mic_clk;
  assign microphone_clock_pin_oe = st_reg.mic_oe;

endmodule // adc_config_irq

// ### design/adc_cfg_pkg.sv
// Functional notes
// - Three-bit selector routes inputs, resets to shorted
// - Two-bit reference field, resets to 0.0 V
// - Oversampling field at 7:6 selects 200/100/64/32
// - Two-bit attenuator field selects 0/6.02/9.54 dB
// - Bit 11 chooses single or continuous conversion
// - Bit 18 set bypasses the compensation filter
// - No bypass: result and offset in upper halves
// - Bypass: result and offset in lower halves
// - Bit 20 picks 1.6 or 0.8 MHz mic clock
// - Bit 22 drives mic clock onto its pin
// - Status bit 0 on calibration done, read clears
// - Status bit 2 on conversion done, read clears
// - Status bit 3 shows window hit, read clears
// - Window bit re-evaluated at every end of conversion while the comparator is enabled
// - Masked status shows flags whose mask is zero
// - Comparator works only while its enable is set
package adc_cfg_pkg;
  // Clock and microphone clock rates
  localparam longint CLK_HZ      = 64'd20000000;
  localparam longint MIC_FAST_HZ = 64'd1600000;
  localparam longint MIC_SLOW_HZ = 64'd800000;
  localparam int     ACC_W       = 16;
  // Phase steps per clock, derived from the rates
  localparam logic [ACC_W-1:0] MIC_STEP_FAST =
    ACC_W'((MIC_FAST_HZ * 64'd65536) / CLK_HZ);
  localparam logic [ACC_W-1:0] MIC_STEP_SLOW =
    ACC_W'((MIC_SLOW_HZ * 64'd65536) / CLK_HZ);
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADC_CONFIGURATION   = 8'h04;
  localparam logic [7:0] OFF_IRQ    = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0c;
  localparam logic [7:0] OFF_RAW    = 8'h10;
  localparam logic [7:0] OFF_DATA   = 8'h14;
  localparam logic [7:0] OFF_OFFSET = 8'h18;
  localparam logic [7:0] OFF_THR_HI = 8'h24;
  localparam logic [7:0] OFF_THR_LO = 8'h28;
  // Field positions
  localparam int INPUT_CHANNEL_SELECT_LSB  = 1;
  localparam int REF_LSB    = 4;
  localparam int OSR_LSB    = 6;
  localparam int ATT_LSB    = 8;
  localparam int REPEAT_BIT = 11;
  localparam int SKIP_BIT   = 18;
  localparam int RATE_BIT   = 20;
  localparam int MICOUT_BIT = 22;
  localparam int CMP_EN_BIT = 5;
  localparam int FLAG_CAL   = 0;
  localparam int FLAG_EOC   = 2;
  localparam int FLAG_WIN   = 3;
  localparam int NFLAG      = 4;
  // Writable bits and live flag bits
  localparam logic [31:0] ADC_CONFIGURATION_WMASK = 32'h0054_0bfe;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0020;
  localparam logic [31:0] MASK_WMASK = 32'h0000_000f;
  localparam logic [31:0] FLAG_BITS  = 32'h0000_000d;
  // Values after reset
  localparam logic [31:0] ADC_CONFIGURATION_RST   = 32'h0000_000c;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST   = 32'h0000_000f;
  localparam logic [31:0] THR_HI_RST = 32'h0fff_ffff;
  localparam logic [31:0] ZERO_RST   = 32'h0000_0000;
  // Whole register state of the top module
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] adc_configuration;
    logic [31:0] mask;
    logic [31:0] raw;
    logic [31:0] data;
    logic [31:0] offs;
    logic [31:0] thr_hi;
    logic [31:0] thr_lo;
    logic [31:0] rdata;
    logic        mic_oe; // Pin enable, one cycle late
  } regs_t;
  // Microphone clock generator state
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             clk_out;
  } mic_state_t;
endpackage

// ### design/mic_clk_if.sv
`timescale 1ns/1ps
// Control to and clock from the microphone clock generator
interface mic_clk_if;
  logic rate_slow;  // High selects the slower rate
  logic out_enable; // High runs the clock
  logic mic_clk;    // Generated clock, registered
  modport ctrl (output rate_slow, output out_enable, input mic_clk);
  modport gen  (input rate_slow, input out_enable, output mic_clk);
endinterface

// ### design/mic_clk_gen.sv
`timescale 1ns/1ps
// Phase accumulator clock: mean rate set by a truncated step, one-cycle jitter,
// since neither step divides the accumulator range evenly.
module mic_clk_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Control and clock
  mic_clk_if.gen   mic
);
  adc_cfg_pkg::mic_state_t st_reg;  // Registered state
  adc_cfg_pkg::mic_state_t st_next; // Next state
  logic [adc_cfg_pkg::ACC_W-1:0] step; // Chosen step

  // Next state of the accumulator
  always_comb begin
    step = mic.rate_slow ? adc_cfg_pkg::MIC_STEP_SLOW
                         : adc_cfg_pkg::MIC_STEP_FAST;
    st_next = st_reg;
    if (mic.out_enable) begin
      st_next.acc     = st_reg.acc + step;
      st_next.clk_out = st_reg.acc[adc_cfg_pkg::ACC_W-1];
    end else begin
      // Pin held low while no clock is offered
      st_next.acc     = '0;
      st_next.clk_out = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign mic.mic_clk = st_reg.clk_out;
endmodule // mic_clk_gen

// ### testbench/adc_config_irq_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////
// Port-level checks
////////////////////////////////////////////////////////////////////
module adc_config_irq_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Converter events
  input wire logic        cal_done,
  input wire logic [15:0] cal_result,
  input wire logic        conv_done,
  input wire logic [15:0] conv_result,
  // Controls, words, pin
  input wire logic [2:0]  input_channel_select,
  input wire logic [1:0]  reference_level_select,
  input wire logic [1:0]  oversample_ratio_select,
  input wire logic [1:0]  attenuator_select,
  input wire logic        repeat_convert,
  input wire logic        filter_bypass,
  input wire logic        window_compare_enable,
  input wire logic [31:0] data_word,
  input wire logic [31:0] offset_word,
  input wire logic        microphone_clock_pin,
  input wire logic        microphone_clock_pin_oe
);
  // One domain only
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Field outputs follow a write
  chk_adc_configuration_fields: assert property (ce && wr && addr == 8'h04 |=>
    input_channel_select == $past(wdata[3:1]) && oversample_ratio_select == $past(wdata[7:6])
    && repeat_convert == $past(wdata[11])) else $error("adc_configuration fields wrong");
  chk_adc_configuration_levels: assert property (ce && wr && addr == 8'h04 |=>
    reference_level_select == $past(wdata[5:4]) && attenuator_select == $past(wdata[9:8])
    && filter_bypass == $past(wdata[18])) else $error("adc_configuration levels wrong");
  // Pin enable lags the bit by one cycle
  chk_oe_follow: assert property (ce && wr && addr == 8'h04 ##1 ce |=>
    microphone_clock_pin_oe == $past(wdata[22], 2)) else $error("pin enable wrong");
  chk_pin_idle: assert property (!microphone_clock_pin_oe [*3] |->
    !microphone_clock_pin) else $error("pin active while off");
  // No high phase shorter than six cycles at either rate
  chk_pin_high: assert property ($rose(microphone_clock_pin) |->
    (microphone_clock_pin || !microphone_clock_pin_oe) [*6]) else $error("pin phase short");
  // Result placement by bypass bit
  chk_result_upper: assert property (ce && conv_done && !filter_bypass |=>
    data_word == {$past(conv_result), $past(data_word[15:0])}) else $error("upper result");
  chk_result_lower: assert property (ce && conv_done && filter_bypass |=>
    data_word == {$past(data_word[31:16]), $past(conv_result)}) else $error("lower result");
  chk_cal_place: assert property (ce && cal_done |=>
    ($past(filter_bypass) ? offset_word[15:0] : offset_word[31:16]) == $past(cal_result))
    else $error("offset placement");
  chk_eoc_flag: assert property (ce && conv_done ##1 ce && !rd
    ##1 ce && rd && addr == 8'h10 |=> rdata[2]) else $error("eoc flag missing");
  // Second masked read with no event shows nothing
  chk_read_clears: assert property (ce && rd && addr == 8'h08 && !cal_done && !conv_done
    ##1 ce && !wr && !cal_done && !conv_done
    ##1 ce && rd && addr == 8'h08 |=> rdata == 32'h0)
    else $error("masked read not cleared");
  chk_read_idle: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("read data outside slot");
endmodule // adc_config_irq_props

bind adc_config_irq adc_config_irq_props u_props (.clk, .rstn, .ce, .addr, .wdata, .wr, .rd,
  .rdata, .cal_done, .cal_result, .conv_done, .conv_result, .input_channel_select,
  .reference_level_select, .oversample_ratio_select, .attenuator_select, .repeat_convert,
  .filter_bypass, .window_compare_enable, .data_word, .offset_word, .microphone_clock_pin,
  .microphone_clock_pin_oe);

// ### testbench/adc_config_and_irq_status_bench.sv
`timescale 1ns/1ps
module adc_config_and_irq_status_bench;
  // Design ports
  logic        clk, rstn, ce, wr, rd, cal_done, conv_done, repeat_convert;
  logic        filter_bypass, window_compare_enable, microphone_clock_pin;
  logic        microphone_clock_pin_oe;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, data_word, offset_word;
  logic [15:0] cal_result, conv_result;
  logic [2:0]  input_channel_select;
  logic [1:0]  reference_level_select, oversample_ratio_select, attenuator_select;
  // Bench state and expected words
  int          errors, n_compared, n;
  logic [31:0] v, w, r, dexp, oexp, flg;
  logic        prev, byp;
  adc_config_irq u_dut (.clk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata, .cal_done,
    .cal_result, .conv_done, .conv_result, .input_channel_select, .reference_level_select,
    .oversample_ratio_select, .attenuator_select, .repeat_convert, .filter_bypass,
    .window_compare_enable, .data_word, .offset_word, .microphone_clock_pin,
    .microphone_clock_pin_oe);
  ////////////////////////////////////////////////////////////////////
  // Clock, one comparison, bus and event tasks
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data sampled in its single valid cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Upper half of x goes to calibration, lower to conversion
  task automatic pulse(input logic c, input logic e, input logic [31:0] x);
    @(posedge clk);
    cal_done <= c;
    conv_done <= e;
    cal_result <= x[31:16];
    conv_result <= x[15:0];
    @(posedge clk);
    cal_done <= 1'b0;
    conv_done <= 1'b0;
    #1;
    if (c) oexp = byp ? {oexp[31:16], x[31:16]} : {x[31:16], oexp[15:0]};
    if (e) dexp = byp ? {dexp[31:16], x[15:0]} : {x[15:0], dexp[15:0]};
  endtask
  task automatic count_rises(output int k);
    k = 0;
    prev = microphone_clock_pin;
    repeat (250) begin
      @(posedge clk);
      #1 if (microphone_clock_pin && !prev) k++;
      prev = microphone_clock_pin;
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, far beyond the some 840 cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rstn, wr, rd, cal_done, conv_done, addr, wdata, cal_result, conv_result} = '0;
    ce = 1'b1;
    {errors, n_compared, dexp, oexp, byp} = '0;
    void'($urandom(32'h432ba078));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 check("chan rst", 32'(input_channel_select), 32'h6);
    rd_reg(8'h04, v); check("adc_configuration rst", v, 32'h0000_000c);
    // Every code of every field; read-only bits set but ignored
    for (int i = 0; i < 16; i++) begin
      w = $urandom() & 32'h0054_0bfe;
      {w[3:1], w[7:6], w[5:4], w[9:8]} = {i[2:0], i[1:0], i[3:2], i[3:2]};
      wr_reg(8'h04, w | 32'hffab_f401);
      check("chan", 32'(input_channel_select), 32'(w[3:1]));
      check("ref", 32'(reference_level_select), 32'(w[5:4]));
      check("osr", 32'(oversample_ratio_select), 32'(i[1:0]));
      check("att", 32'(attenuator_select), 32'(w[9:8]));
      check("repeat_convert", 32'(repeat_convert), 32'(w[11]));
      check("skip", 32'(filter_bypass), 32'(w[18]));
      rd_reg(8'h04, v); check("adc_configuration", v, w);
    end
    rd_reg(8'h3c, v); check("unmapped", v, 32'h0);
    $display("config test done");
    // Result and calibration halves for both bypass settings
    for (int i = 0; i < 8; i++) begin
      byp = i[0];
      wr_reg(8'h04, (32'(i[0]) << 18) | 32'h800);
      pulse(1'b1, 1'b0, $urandom());
      repeat (i[0] ? 3 : 10) pulse(1'b0, 1'b1, $urandom());
      pulse(1'b1, 1'b1, $urandom());
      check("data", data_word, dexp);
      check("offset", offset_word, oexp);
      rd_reg(8'h14, v); check("data rd", v, dexp);
    end
    $display("placement test done");
    // Window flags: boundaries then random results
    byp = 1'b0;
    wr_reg(8'h04, 32'h0);
    wr_reg(8'h24, 32'h8000_ffff);
    wr_reg(8'h28, 32'h0001_0000);
    wr_reg(8'h0c, 32'h0);
    wr_reg(8'h00, 32'h20);
    check("cmp on", 32'(window_compare_enable), 32'h1);
    rd_reg(8'h10, v);
    for (int i = 0; i < 10; i++) begin
      r = $urandom();
      if (i < 4) r[15:0] = (i == 0) ? 16'h8000 : (i == 1) ? 16'h8001 : 16'(i - 2);
      pulse(1'b1, 1'b1, r);
      flg = 32'h5 | (32'(dexp >= 32'h0001_0000 && dexp <= 32'h8000_ffff) << 3);
      rd_reg(8'h08, v); check("flags", v, flg);
      rd_reg(8'h08, v); check("flags clr", v, 32'h0);
    end
    // Comparator off: window bit holds its hit
    pulse(1'b0, 1'b1, 32'h0000_8000);
    wr_reg(8'h00, 32'h0);
    check("cmp off", 32'(window_compare_enable), 32'h0);
    pulse(1'b0, 1'b1, 32'h0);
    rd_reg(8'h08, v); check("hold", v, 32'hc);
    // Masked sources hidden, raw still set
    wr_reg(8'h0c, 32'hf);
    pulse(1'b1, 1'b1, $urandom());
    rd_reg(8'h08, v); check("masked", v, 32'h0);
    // Event beside a raw read survives it
    @(posedge clk);
    addr <= 8'h10;
    rd <= 1'b1;
    conv_done <= 1'b1;
    @(posedge clk);
    {rd, conv_done} <= 2'b00;
    #1 check("raw old", rdata, 32'h5);
    rd_reg(8'h10, v); check("raw new", v, 32'h4);
    $display("flag test done");
    // Microphone clock at both rates, then off
    wr_reg(8'h04, 32'h0040_0000);
    @(posedge clk);
    #1 check("oe on", 32'(microphone_clock_pin_oe), 32'h1);
    count_rises(n); check("fast", 32'(n >= 19 && n <= 21), 32'h1);
    wr_reg(8'h04, 32'h0050_0000);
    count_rises(n); check("slow", 32'(n >= 9 && n <= 11), 32'h1);
    wr_reg(8'h04, 32'h0);
    repeat (3) @(posedge clk);
    #1 check("pin off", 32'({microphone_clock_pin, microphone_clock_pin_oe}), 32'h0);
    $display("clock test done");
    test_done();
  end
endmodule // adc_config_and_irq_status_bench
